// [common/sbat_map.svh]
`ifndef SBAT_MAP_SVH
`define SBAT_MAP_SVH

// Bus widths
`define SBAT_DATA_W      64
`define SBAT_HALF_W      32

// Positions of the control pins in the synchroniser vector
`define SBAT_IX_BR       0
`define SBAT_IX_BG       1
`define SBAT_IX_ABB      2
`define SBAT_IX_TS       3
`define SBAT_IX_ADDRESS_ACKNOWLEDGE     4
`define SBAT_IX_ADDRESS_RETRY    5
`define SBAT_IX_DBG      6
`define SBAT_IX_DBB      7
`define SBAT_IX_TA       8
`define SBAT_IX_DATA     9
`define SBAT_CTL_N       9

// Pin levels and reset values
`define SBAT_PIN_NEG     1'b1
`define SBAT_PIN_ASSERT  1'b0

// Cycles after an own transfer start during which a start seen on the
// pin is taken as the echo of our own drive
`define SBAT_QUIET_CYCLES 3'h4

`endif

// [common/sbat_pkg.sv]
package sbat_pkg;
    typedef enum logic [1:0] {A_IDLE, A_REQ, A_TEN, A_REL} sbat_addr_type;
    typedef enum logic [1:0] {D_IDLE, D_WAIT, D_TEN, D_REL} sbat_data_type;
    typedef enum logic [2:0] {
        G_IDLE, G_ABUS, G_AWAIT, G_DBUS, G_DWAIT
    } sbat_arb_type;
    typedef enum logic [1:0] {R_IDLE, R_ACK, R_REL} sbat_resp_type;
endpackage : sbat_pkg

// [common/sbat_sync_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface sbat_sync_if #(parameter int W = 1);
    logic [W-1:0] raw;
    logic [W-1:0] clean;
    modport src  (output raw, input clean);
    modport sync (input raw, output clean);
endinterface : sbat_sync_if
`default_nettype wire

// [verilog/sbat_sync.sv]
`timescale 1ns/1ns
`default_nettype none
`include "sbat_map.svh"
module sbat_sync (
    input  wire logic    ref_clk_in,
    input  wire logic    rst_in,
    sbat_sync_if.sync    bus
);
    localparam int W = $bits(bus.raw);

    // Three stages; a change counts once stages two and three agree
    genvar i;
    for (i = 0; i < W; i++) begin : g_bit
        logic s1_reg, s2_reg, s3_reg, q_reg;
        logic q_next;
        always_comb begin
            q_next = (s2_reg == s3_reg) ? s3_reg : q_reg;
        end
        always_ff @(posedge ref_clk_in or posedge rst_in) begin
            if (rst_in) begin
                s1_reg <= `SBAT_PIN_NEG;
                s2_reg <= `SBAT_PIN_NEG;
                s3_reg <= `SBAT_PIN_NEG;
                q_reg  <= `SBAT_PIN_NEG;
            end else begin
                s1_reg <= bus.raw[i];
                s2_reg <= s1_reg;
                s3_reg <= s2_reg;
                q_reg  <= q_next;
            end
        end
        assign bus.clean[i] = q_reg;
    end
endmodule : sbat_sync
`default_nettype wire

// [verilog/sbat_arbiter.sv]
// Functional notes
// RULE1 - External arbiter: drive and assert bus request
// RULE2 - On-chip arbiter: bus request is external input
// RULE3 - On-chip arbiter: drive bus grant to externals
// RULE4 - External arbiter grants us via bus grant
// RULE5 - Hold address busy through own address tenure
// RULE6 - After acknowledge, negate address busy, then release
// RULE7 - Never take address bus while others busy
// RULE8 - Pulse transfer start at own tenure start
// RULE9 - Respond to external transfer start as needed
// RULE10 - Address acknowledge ends the address tenure
// RULE11 - Retry means master retries later; snoop retries
// RULE12 - On-chip arbiter: drive data bus grant out
// RULE13 - External arbiter grants data bus to us
// RULE14 - Hold data busy through own data tenure
// RULE15 - After transfer acknowledge, negate, then release
// RULE16 - Never take data bus while others busy
// RULE17 - Writer drives upper word, slave on reads
// RULE18 - Host port off 64-bit, on 32-bit
// RULE19 - Arbiter choice static, sets pin directions
`timescale 1ns/1ns
`default_nettype none
`include "sbat_map.svh"
module sbat_arbiter #(
    parameter int DATA_W = `SBAT_DATA_W
) (
    input  wire logic              ref_clk_in,
    input  wire logic              rst_in,
    input  wire logic              ext_arb_strap_in,
    input  wire logic              host_port_en_in,
    input  wire logic              snoop_en_in,
    input  wire logic              mst_req_in,
    input  wire logic              mst_write_in,
    input  wire logic [DATA_W-1:0] mst_wdata_in,
    output logic                   mst_addr_done_out,
    output logic                   mst_retry_out,
    output logic                   mst_data_done_out,
    output logic [DATA_W-1:0]      mst_rdata_out,
    input  wire logic              own_addr_hit_in,
    input  wire logic              snoop_hit_in,
    output logic                   ext_tenure_out,
    input  wire logic              bus_request_n_in,
    output logic                   bus_request_n_out,
    output logic                   bus_request_oe_out,
    input  wire logic              bus_grant_n_in,
    output logic                   bus_grant_n_out,
    output logic                   bus_grant_oe_out,
    input  wire logic              address_busy_n_in,
    output logic                   address_busy_n_out,
    output logic                   address_busy_oe_out,
    input  wire logic              transfer_start_n_in,
    output logic                   transfer_start_n_out,
    output logic                   transfer_start_oe_out,
    input  wire logic              address_acknowledge_n_in,
    output logic                   address_acknowledge_n_out,
    output logic                   address_acknowledge_oe_out,
    input  wire logic              address_retry_n_in,
    output logic                   address_retry_n_out,
    output logic                   address_retry_oe_out,
    input  wire logic              data_bus_grant_n_in,
    output logic                   data_bus_grant_n_out,
    output logic                   data_bus_grant_oe_out,
    input  wire logic              data_busy_n_in,
    output logic                   data_busy_n_out,
    output logic                   data_busy_oe_out,
    input  wire logic              transfer_acknowledge_n_in,
    input  wire logic [DATA_W-1:0] data_in,
    output logic [DATA_W-1:0]      data_out,
    output logic [1:0]             data_oe_out
);
    localparam int HW = `SBAT_HALF_W;
    localparam int SW = `SBAT_CTL_N + DATA_W;

    if (DATA_W != 2 * HW) begin : g_check
        $error("DATA_W must be twice the half word");
    end

    sbat_sync_if #(.W(SW)) sy ();
    assign sy.raw = {data_in, transfer_acknowledge_n_in, data_busy_n_in,
                     data_bus_grant_n_in, address_retry_n_in,
                     address_acknowledge_n_in, transfer_start_n_in,
                     address_busy_n_in, bus_grant_n_in, bus_request_n_in};

    sbat_sync u_sync (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .bus        (sy)
    );

    logic              s_br, s_bg, s_abb, s_ts, s_address_acknowledge, s_address_retry;
    logic              s_dbg, s_dbb, s_ta;
    logic [DATA_W-1:0] s_data;
    assign s_br    = ~sy.clean[`SBAT_IX_BR];
    assign s_bg    = ~sy.clean[`SBAT_IX_BG];
    assign s_abb   = ~sy.clean[`SBAT_IX_ABB];
    assign s_ts    = ~sy.clean[`SBAT_IX_TS];
    assign s_address_acknowledge  = ~sy.clean[`SBAT_IX_ADDRESS_ACKNOWLEDGE];
    assign s_address_retry = ~sy.clean[`SBAT_IX_ADDRESS_RETRY];
    assign s_dbg   = ~sy.clean[`SBAT_IX_DBG];
    assign s_dbb   = ~sy.clean[`SBAT_IX_DBB];
    assign s_ta    = ~sy.clean[`SBAT_IX_TA];
    assign s_data  = sy.clean[SW-1:`SBAT_IX_DATA];

    sbat_pkg::sbat_addr_type a_reg, a_next;
    sbat_pkg::sbat_data_type d_reg, d_next;
    sbat_pkg::sbat_arb_type  g_reg, g_next;
    sbat_pkg::sbat_resp_type r_reg, r_next;
    logic              ext_mode_reg, ext_mode_next;
    logic              mode_ok_reg, mode_ok_next;
    logic              wr_reg, wr_next;
    logic              ts_prev_reg;
    logic [2:0]        quiet_reg, quiet_next;
    logic              br_n_next, br_oe_next, bg_n_next, bg_oe_next;
    logic              abb_n_next, abb_oe_next, ts_n_next, ts_oe_next;
    logic              address_acknowledge_n_next, address_acknowledge_oe_next, rty_n_next, rty_oe_next;
    logic              dbg_n_next, dbg_oe_next, dbb_n_next, dbb_oe_next;
    logic              adone_next, retry_next, ddone_next, ext_ten_next;
    logic [DATA_W-1:0] rdata_next, dout_next;
    logic [1:0]        doe_next;
    logic              agrant, dgrant, ext_ts, resp_go, hit_own, hit_snp;

    // Own one-cycle start never passes the synchroniser; mask it out as well
    assign ext_ts  = s_ts & ~ts_prev_reg & (quiet_reg == 3'h0)
                     & ~transfer_start_oe_out;                     // RULE9
    assign hit_own = own_addr_hit_in;
    assign hit_snp = snoop_en_in & snoop_hit_in;
    assign resp_go = (r_reg == sbat_pkg::R_IDLE) & ext_ts
                     & (hit_own | hit_snp);
    assign agrant  = ext_mode_reg ? s_bg                           // RULE4
                   : (g_reg == sbat_pkg::G_IDLE) & ~s_br;          // RULE2
    assign dgrant  = ext_mode_reg ? s_dbg : 1'b1;                  // RULE13

    always_comb begin
        a_next        = a_reg;
        d_next        = d_reg;
        g_next        = g_reg;
        r_next        = r_reg;
        wr_next       = wr_reg;
        ext_mode_next = ext_mode_reg;
        mode_ok_next  = 1'b1;
        quiet_next    = (quiet_reg == 3'h0) ? 3'h0 : quiet_reg - 3'h1;
        adone_next    = 1'b0;
        retry_next    = 1'b0;
        ddone_next    = 1'b0;
        ext_ten_next  = ext_ts;
        rdata_next    = mst_rdata_out;
        if (!mode_ok_reg) begin
            ext_mode_next = ext_arb_strap_in;                      // RULE19
        end
        unique case (a_reg)
            sbat_pkg::A_IDLE: begin
                if (mst_req_in && mode_ok_reg && d_reg == sbat_pkg::D_IDLE)
                    a_next = sbat_pkg::A_REQ;
            end
            sbat_pkg::A_REQ: begin
                if (agrant && !s_abb) begin                        // RULE7
                    a_next     = sbat_pkg::A_TEN;
                    wr_next    = mst_write_in;
                    quiet_next = `SBAT_QUIET_CYCLES;
                end
            end
            sbat_pkg::A_TEN: begin
                if (s_address_acknowledge) begin                                  // RULE10
                    a_next = sbat_pkg::A_REL;
                    if (s_address_retry) begin
                        retry_next = 1'b1;                         // RULE11
                    end else begin
                        adone_next = 1'b1;
                        d_next     = sbat_pkg::D_WAIT;
                    end
                end
            end
            sbat_pkg::A_REL: a_next = sbat_pkg::A_IDLE;
        endcase
        unique case (d_reg)
            sbat_pkg::D_IDLE: ;
            sbat_pkg::D_WAIT: begin
                if (dgrant && !s_dbb)                              // RULE16
                    d_next = sbat_pkg::D_TEN;
            end
            sbat_pkg::D_TEN: begin
                if (s_ta) begin
                    d_next     = sbat_pkg::D_REL;
                    ddone_next = 1'b1;
                    if (!wr_reg)                                   // RULE17
                        rdata_next = host_port_en_in
                            ? {{HW{1'b0}}, s_data[DATA_W-1:HW]}    // RULE18
                            : s_data;
                end
            end
            sbat_pkg::D_REL: d_next = sbat_pkg::D_IDLE;
        endcase
        unique case (g_reg)
            sbat_pkg::G_IDLE: begin
                if (!ext_mode_reg && mode_ok_reg && s_br
                    && a_reg == sbat_pkg::A_IDLE)
                    g_next = sbat_pkg::G_ABUS;
            end
            sbat_pkg::G_ABUS: if (ext_ts) g_next = sbat_pkg::G_AWAIT;
            sbat_pkg::G_AWAIT: begin
                // Own one-cycle response never passes the pin filter
                if (s_address_acknowledge || r_reg == sbat_pkg::R_ACK)            // RULE10
                    g_next = (s_address_retry || !address_retry_n_out)
                           ? sbat_pkg::G_IDLE : sbat_pkg::G_DBUS;
            end
            sbat_pkg::G_DBUS: if (s_dbb) g_next = sbat_pkg::G_DWAIT;
            sbat_pkg::G_DWAIT: if (!s_dbb) g_next = sbat_pkg::G_IDLE;
            default: g_next = sbat_pkg::G_IDLE;
        endcase
        unique case (r_reg)
            sbat_pkg::R_IDLE: if (resp_go) r_next = sbat_pkg::R_ACK;
            sbat_pkg::R_ACK:  r_next = sbat_pkg::R_REL;
            sbat_pkg::R_REL:  r_next = sbat_pkg::R_IDLE;
            default:          r_next = sbat_pkg::R_IDLE;
        endcase

        // Pin drives: asserted low; busy and response pins are then negated for one cycle and released, request and grants stay driven
        br_oe_next  = ext_mode_next & mode_ok_next;                // RULE19
        br_n_next   = ~(ext_mode_reg & (a_next == sbat_pkg::A_REQ)); // RULE1
        bg_oe_next  = ~ext_mode_next & mode_ok_next;
        bg_n_next   = ~(g_next == sbat_pkg::G_ABUS);               // RULE3
        dbg_oe_next = ~ext_mode_next & mode_ok_next;
        dbg_n_next  = ~(g_next == sbat_pkg::G_DBUS);               // RULE12
        ts_oe_next  = (a_next == sbat_pkg::A_TEN);
        ts_n_next   = ~(a_next == sbat_pkg::A_TEN
                        && a_reg != sbat_pkg::A_TEN);              // RULE8
        abb_oe_next = (a_next == sbat_pkg::A_TEN)
                    | (a_next == sbat_pkg::A_REL);
        abb_n_next  = (a_next == sbat_pkg::A_REL);                 // RULE5 RULE6
        dbb_oe_next = (d_next == sbat_pkg::D_TEN)
                    | (d_next == sbat_pkg::D_REL);
        dbb_n_next  = (d_next == sbat_pkg::D_REL);                 // RULE14 RULE15
        address_acknowledge_oe_next = (resp_go & hit_own)
                     | ((r_reg == sbat_pkg::R_ACK) & address_acknowledge_oe_out);
        address_acknowledge_n_next  = ~(resp_go & hit_own);                       // RULE10
        rty_oe_next  = (resp_go & hit_snp)
                     | ((r_reg == sbat_pkg::R_ACK) & address_retry_oe_out);
        rty_n_next   = ~(resp_go & hit_snp);                       // RULE11
        dout_next   = host_port_en_in
                    ? {mst_wdata_in[HW-1:0], {HW{1'b0}}} : mst_wdata_in;
        doe_next[1] = wr_next & (d_next == sbat_pkg::D_TEN);       // RULE17
        doe_next[0] = doe_next[1] & ~host_port_en_in;              // RULE18
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            a_reg <= sbat_pkg::A_IDLE;
            d_reg <= sbat_pkg::D_IDLE;
            g_reg <= sbat_pkg::G_IDLE;
            r_reg <= sbat_pkg::R_IDLE;
            ext_mode_reg <= 1'b0;
            mode_ok_reg  <= 1'b0;
            wr_reg       <= 1'b0;
            ts_prev_reg  <= 1'b0;
            quiet_reg    <= 3'h0;
            mst_addr_done_out <= 1'b0;
            mst_retry_out     <= 1'b0;
            mst_data_done_out <= 1'b0;
            mst_rdata_out     <= '0;
            ext_tenure_out    <= 1'b0;
            bus_request_n_out <= `SBAT_PIN_NEG;
            bus_request_oe_out <= 1'b0;
            bus_grant_n_out   <= `SBAT_PIN_NEG;
            bus_grant_oe_out  <= 1'b0;
            address_busy_n_out <= `SBAT_PIN_NEG;
            address_busy_oe_out <= 1'b0;
            transfer_start_n_out <= `SBAT_PIN_NEG;
            transfer_start_oe_out <= 1'b0;
            address_acknowledge_n_out <= `SBAT_PIN_NEG;
            address_acknowledge_oe_out <= 1'b0;
            address_retry_n_out <= `SBAT_PIN_NEG;
            address_retry_oe_out <= 1'b0;
            data_bus_grant_n_out <= `SBAT_PIN_NEG;
            data_bus_grant_oe_out <= 1'b0;
            data_busy_n_out <= `SBAT_PIN_NEG;
            data_busy_oe_out <= 1'b0;
            data_out    <= '0;
            data_oe_out <= 2'h0;
        end else begin
            a_reg <= a_next;
            d_reg <= d_next;
            g_reg <= g_next;
            r_reg <= r_next;
            ext_mode_reg <= ext_mode_next;
            mode_ok_reg  <= mode_ok_next;
            wr_reg       <= wr_next;
            ts_prev_reg  <= s_ts;
            quiet_reg    <= quiet_next;
            mst_addr_done_out <= adone_next;
            mst_retry_out     <= retry_next;
            mst_data_done_out <= ddone_next;
            mst_rdata_out     <= rdata_next;
            ext_tenure_out    <= ext_ten_next;
            bus_request_n_out <= br_n_next;
            bus_request_oe_out <= br_oe_next;
            bus_grant_n_out   <= bg_n_next;
            bus_grant_oe_out  <= bg_oe_next;
            address_busy_n_out <= abb_n_next;
            address_busy_oe_out <= abb_oe_next;
            transfer_start_n_out <= ts_n_next;
            transfer_start_oe_out <= ts_oe_next;
            address_acknowledge_n_out <= address_acknowledge_n_next;
            address_acknowledge_oe_out <= address_acknowledge_oe_next;
            address_retry_n_out <= rty_n_next;
            address_retry_oe_out <= rty_oe_next;
            data_bus_grant_n_out <= dbg_n_next;
            data_bus_grant_oe_out <= dbg_oe_next;
            data_busy_n_out <= dbb_n_next;
            data_busy_oe_out <= dbb_oe_next;
            data_out    <= dout_next;
            data_oe_out <= doe_next;
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    sequence seq_addr_end;
        a_reg == sbat_pkg::A_TEN ##1 a_reg == sbat_pkg::A_REL;
    endsequence
    sequence seq_data_end;
        d_reg == sbat_pkg::D_TEN ##1 d_reg == sbat_pkg::D_REL;
    endsequence
    sequence seq_addr_start;
        a_reg == sbat_pkg::A_REQ ##1 a_reg == sbat_pkg::A_TEN;
    endsequence

    AST_BR_REQ: assert property (ext_mode_reg && a_reg == sbat_pkg::A_REQ // RULE1
        |-> bus_request_oe_out && !bus_request_n_out)
        else $error("bus request not asserted while requesting");
    AST_BG_OUT: assert property (g_reg == sbat_pkg::G_ABUS // RULE3
        |-> bus_grant_oe_out && !bus_grant_n_out && !ext_mode_reg)
        else $error("bus grant not driven to external master");
    AST_ABB_HOLD: assert property (a_reg == sbat_pkg::A_TEN // RULE5
        |-> address_busy_oe_out && !address_busy_n_out)
        else $error("address busy dropped during tenure");
    AST_ABB_REL: assert property (seq_addr_end // RULE6
        |-> address_busy_oe_out && address_busy_n_out
            ##1 !address_busy_oe_out)
        else $error("address busy not negated then released");
    AST_ABB_BLOCK: assert property (a_reg == sbat_pkg::A_REQ && s_abb // RULE7
        |=> a_reg != sbat_pkg::A_TEN)
        else $error("address bus taken while busy");
    AST_TS_PULSE: assert property (seq_addr_start // RULE8
        |-> !transfer_start_n_out ##1
            (transfer_start_n_out || a_reg != sbat_pkg::A_TEN))
        else $error("transfer start not a one-cycle pulse");
    AST_ADDRESS_ACKNOWLEDGE_RESP: assert property (resp_go && hit_own // RULE10
        |=> address_acknowledge_oe_out && !address_acknowledge_n_out
            ##1 address_acknowledge_n_out ##1 !address_acknowledge_oe_out)
        else $error("address acknowledge response wrong");
    AST_RETRY: assert property (a_reg == sbat_pkg::A_TEN && s_address_acknowledge // RULE11
        && s_address_retry |=> mst_retry_out && !mst_addr_done_out
        && d_reg == sbat_pkg::D_IDLE)
        else $error("retried tenure not reported");
    AST_DBG_OUT: assert property (g_reg == sbat_pkg::G_DBUS // RULE12
        |-> data_bus_grant_oe_out && !data_bus_grant_n_out)
        else $error("data bus grant not driven");
    AST_DBB_HOLD: assert property (d_reg == sbat_pkg::D_TEN // RULE14
        |-> data_busy_oe_out && !data_busy_n_out)
        else $error("data busy dropped during tenure");
    AST_DBB_REL: assert property (seq_data_end // RULE15
        |-> data_busy_oe_out && data_busy_n_out ##1 !data_busy_oe_out)
        else $error("data busy not negated then released");
    AST_DBB_BLOCK: assert property (d_reg == sbat_pkg::D_WAIT && s_dbb // RULE16
        |=> d_reg == sbat_pkg::D_WAIT)
        else $error("data bus taken while busy");
    AST_HALF: assert property ($past(host_port_en_in) // RULE18
        |-> !data_oe_out[0])
        else $error("lower word driven in 32-bit mode");
    AST_DIR: assert property (mode_ok_reg && ext_mode_reg // RULE19
        |-> !bus_grant_oe_out && !data_bus_grant_oe_out && bus_request_oe_out)
        else $error("pin directions do not follow arbiter choice");
endmodule : sbat_arbiter
`default_nettype wire

// [verif/sbat_partner.sv]
`timescale 1ns/1ns
`default_nettype none
module sbat_partner (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic [3:0]  dly_in,
    input  wire logic        retry_in,
    input  wire logic [63:0] rd_in,
    input  wire logic [7:0]  pin_in,
    output logic [7:0]       drv_out,
    output logic             ta_n_out,
    output logic [63:0]      data_out
);
    logic [3:0] cnt_reg;
    logic       ten_reg;
    // Outside the acknowledge the bus shows the inverted read data, not the read data
    assign data_out = ta_n_out ? ~rd_in : rd_in;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            drv_out  <= 8'hff;
            ta_n_out <= 1'b1;
            cnt_reg  <= 4'h0;
            ten_reg  <= 1'b0;
        end else begin
            cnt_reg  <= cnt_reg + 4'h1;
            ta_n_out <= pin_in[7];
            if (!pin_in[0] && cnt_reg >= dly_in) drv_out[1] <= 1'b0;
            if (!pin_in[3] && !drv_out[1]) begin
                drv_out[1] <= 1'b1;
                ten_reg    <= 1'b1;
                cnt_reg    <= 4'h0;
            end
            if (ten_reg && cnt_reg == dly_in) begin
                drv_out[4] <= 1'b0;
                drv_out[5] <= !retry_in;
            end
            // Acknowledge is held until the tenure owner lets go
            if (!drv_out[4] && pin_in[2]) begin
                drv_out[5:4] <= 2'h3;
                drv_out[6]   <= retry_in;
                ten_reg      <= 1'b0;
            end
            if (!pin_in[7]) drv_out[6] <= 1'b1;
        end
    end
endmodule : sbat_partner
`default_nettype wire

// [verif/tb_sbat_arbiter.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin \
    fail_count++; $display("unexpected %s: expected %h seen %h", nm, ex, gt); \
    end end
module tb_sbat_arbiter;
    logic        ref_clk_in = 1'b0;
    logic        rst_in = 1'b1, strap = 1'b1, host = 1'b0, req = 1'b0;
    logic        wr = 1'b0, own_hit = 1'b0, snoop_hit = 1'b0, retry = 1'b0;
    logic        tb_br = 1'b1, tb_abb = 1'b1, tb_ts = 1'b1;
    logic [3:0]  dly = 4'h0;
    logic [63:0] wdata = 64'h0, rd = 64'h0, rdata, d_o, p_d, dbus, seen;
    wire  [7:0]  n_o, oe;
    logic [7:0]  pin, drv;
    logic [1:0]  d_oe, oe_seen = 2'b00;
    logic        addr_done, retry_o, data_done, ext_ten, ta_n;
    logic [5:0]  ev;
    logic [67:0] exp_q[$];
    int          fail_count = 0, total_checks = 0;

    always #25 ref_clk_in = ~ref_clk_in;
    // Released control lines follow the partner or testbench drive; data busy is pulled up
    assign pin = (oe & n_o)
               | (~oe & {1'b1, drv[6:4], tb_ts, tb_abb, drv[1], tb_br});
    assign dbus = {d_oe[1] ? d_o[63:32] : p_d[63:32],
                   d_oe[0] ? d_o[31:0] : p_d[31:0]};
    assign ev = {~pin[6], ~pin[1], ext_ten, data_done, retry_o, addr_done};

    sbat_partner partner (.clk_in(ref_clk_in), .rst_in(rst_in), .dly_in(dly),
        .retry_in(retry), .rd_in(rd), .pin_in(pin), .drv_out(drv),
        .ta_n_out(ta_n), .data_out(p_d));
    sbat_arbiter dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .ext_arb_strap_in(strap), .host_port_en_in(host), .snoop_en_in(1'b1),
        .mst_req_in(req), .mst_write_in(wr), .mst_wdata_in(wdata),
        .mst_addr_done_out(addr_done), .mst_retry_out(retry_o),
        .mst_data_done_out(data_done), .mst_rdata_out(rdata),
        .own_addr_hit_in(own_hit), .snoop_hit_in(snoop_hit),
        .ext_tenure_out(ext_ten), .bus_request_n_in(pin[0]),
        .bus_request_n_out(n_o[0]), .bus_request_oe_out(oe[0]),
        .bus_grant_n_in(pin[1]), .bus_grant_n_out(n_o[1]),
        .bus_grant_oe_out(oe[1]), .address_busy_n_in(pin[2]),
        .address_busy_n_out(n_o[2]), .address_busy_oe_out(oe[2]),
        .transfer_start_n_in(pin[3]), .transfer_start_n_out(n_o[3]),
        .transfer_start_oe_out(oe[3]), .address_acknowledge_n_in(pin[4]),
        .address_acknowledge_n_out(n_o[4]), .address_acknowledge_oe_out(oe[4]),
        .address_retry_n_in(pin[5]), .address_retry_n_out(n_o[5]),
        .address_retry_oe_out(oe[5]), .data_bus_grant_n_in(pin[6]),
        .data_bus_grant_n_out(n_o[6]), .data_bus_grant_oe_out(oe[6]),
        .data_busy_n_in(pin[7]), .data_busy_n_out(n_o[7]),
        .data_busy_oe_out(oe[7]), .transfer_acknowledge_n_in(ta_n),
        .data_in(dbus), .data_out(d_o), .data_oe_out(d_oe));

    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test

    task automatic step;
        @(posedge ref_clk_in);
        #1;
    endtask : step

    task automatic wait_ev(input logic [5:0] m, output int ts_n);
        int n;
        n = 0;
        ts_n = 0;
        while ((|(ev & m)) !== 1'b1) begin
            step();
            ts_n += (oe[3] === 1'b1 && pin[3] === 1'b0);
            n++;
            if (n > 400) begin
                fail_count++;
                $display("unexpected timeout waiting on mask %h", m);
                stop_test();
            end
        end
    endtask : wait_ev

    task automatic xfer(input logic w, hp, rt, hold);
        logic [63:0] v;
        int          t;
        v = {$urandom, $urandom};
        dly = 4'($urandom_range(7));
        host = hp;
        wr = w;
        retry = rt;
        tb_abb = !hold;
        if (w) wdata = v;
        else rd = v;
        if (!rt) exp_q.push_back({hp, w, !hp & w, !w, hp ? {32'h0, w ?
            v[31:0] : v[63:32]} : v});
        req = 1'b1;
        step();
        step();
        `CHK("request pin", 2'b10, {oe[0], pin[0]})
        if (hold) begin
            t = 0;
            repeat (30) begin
                step();
                t += (oe[3] !== 1'b0);
            end
            `CHK("start while busy", 0, t)
            tb_abb = 1'b1;
        end
        wait_ev(6'h03, t);
        `CHK("start pulses", 1, t)
        `CHK("address end", {rt, !rt}, {retry_o, addr_done})
        `CHK("address busy negated", 2'b11, {oe[2], n_o[2]})
        req = 1'b0;
        step();
        `CHK("address busy released", 1'b0, oe[2])
        if (!rt) begin
            wait_ev(6'h04, t);
            `CHK("data busy negated", 2'b11, {oe[7], n_o[7]})
            step();
            `CHK("data busy released", 1'b0, oe[7])
        end
    endtask : xfer

    always @(posedge ref_clk_in) begin : watch
        logic [67:0] e;
        logic [63:0] got;
        if (d_oe !== 2'b00) begin
            seen <= dbus;
            oe_seen <= oe_seen | d_oe;
            `CHK("data busy held", 1'b0, pin[7])
        end
        if (data_done === 1'b1) begin
            e = exp_q.pop_front();
            got = e[64] ? rdata : seen;
            if (e[67]) got = {32'h0, e[64] ? rdata[31:0] : seen[63:32]};
            `CHK("data word", e[63:0], got)
            `CHK("data drive", e[66:65], oe_seen)
            oe_seen <= 2'b00;
        end
    end

    initial begin : main
        int t;
        void'($urandom(32'hb946));
        repeat (20) @(posedge ref_clk_in);
        #1;
        rst_in = 1'b0;
        repeat (3) step();
        `CHK("pin directions", 3'b001, {oe[1], oe[6], oe[0]})
        for (int i = 0; i < 4; i++) xfer(i[0], i[1], 1'b0, 1'b0);
        xfer(1'b1, 1'b0, 1'b1, 1'b0);
        xfer(1'b0, 1'b0, 1'b0, 1'b1);
        for (int k = 0; k < 2; k++) begin
            own_hit = (k == 0);
            snoop_hit = (k == 1);
            tb_ts = 1'b0;
            // A start shorter than two cycles is lost in the pin filter
            repeat (2) step();
            tb_ts = 1'b1;
            wait_ev(6'h08, t);
            `CHK("response", k ? 2'b01 : 2'b10, {pin[5], pin[4]})
            repeat (6) step();
        end
        strap = 1'b0;
        rst_in = 1'b1;
        step();
        rst_in = 1'b0;
        repeat (3) step();
        `CHK("pin directions", 3'b110, {oe[1], oe[6], oe[0]})
        own_hit = 1'b1;
        snoop_hit = 1'b0;
        tb_br = 1'b0;
        wait_ev(6'h10, t);
        `CHK("bus grant", 2'b10, {oe[1], pin[1]})
        tb_br = 1'b1;
        tb_ts = 1'b0;
        repeat (2) step();
        tb_ts = 1'b1;
        wait_ev(6'h20, t);
        `CHK("data grant", 2'b10, {oe[6], pin[6]})
        stop_test();
    end
endmodule : tb_sbat_arbiter
`default_nettype wire
